/* File: inc/sls_pkg.sv */
// Purpose: shared constants and carriers for the receive link sync/setup block
// Assumes: 8-bit register port, 12-bit register addresses, 8 lanes of 8-bit data
// Notes: all reset values are zero except the crossbar, which resets to identity
package sls_pkg;
  localparam int LANES = 8;
  localparam int LANE_W = 8;
  localparam int SEL_W = 3;

  // register offsets
  localparam logic [11:0] ADDR_SYNC_CTL = 12'h03A;
  localparam logic [11:0] ADDR_SYNC_STAT = 12'h03B;
  localparam logic [11:0] ADDR_LINK_CTL = 12'h300;
  localparam logic [11:0] ADDR_SUBCLASS = 12'h301;
  localparam logic [11:0] ADDR_FC_DELAY_A = 12'h304;
  localparam logic [11:0] ADDR_FC_DELAY_B = 12'h305;
  localparam logic [11:0] ADDR_FC_VAR_A = 12'h306;
  localparam logic [11:0] ADDR_FC_VAR_B = 12'h307;
  localparam logic [11:0] ADDR_XBAR0 = 12'h308;
  localparam logic [11:0] ADDR_XBAR3 = 12'h30B;
  localparam logic [11:0] ADDR_POL_INV = 12'h334;
  localparam logic [11:0] ADDR_CFG0 = 12'h450;
  localparam logic [11:0] ADDR_CFG_LAST = 12'h45A;
  localparam logic [11:0] ADDR_CHKSUM = 12'h45D;
  localparam int CFG_N = 11;

  // field positions
  localparam int SYNC_ONESHOT_BIT = 0;
  localparam int SYNC_ARM_BIT = 6;
  localparam int SYNC_EN_BIT = 7;
  localparam int STAT_LOCK_BIT = 3;
  localparam int LINK_CSUM_BIT = 6;
  localparam int LINK_DUAL_BIT = 3;
  localparam int SUBCLASS_BIT = 0;
  localparam int DLY_W = 5;
  // field positions inside the configuration byte table (index from 0x450)
  localparam int CFG_L = 3;
  localparam int CFG_K = 5;
  localparam int CFG_M = 6;
  localparam int CFG_N1 = 7;
  localparam int CFG_NP = 8;
  localparam int CFG_S = 9;
  localparam int CFG_DENSITY = 10;
  localparam int SCR_BIT = 7;
  localparam int CFG_SUBCLASS_BIT = 5;
  localparam int DENSITY_BIT = 7;

  // reset values and link enable field codes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_XBAR0 = 8'h08;
  localparam logic [7:0] RST_XBAR1 = 8'h1A;
  localparam logic [7:0] RST_XBAR2 = 8'h2C;
  localparam logic [7:0] RST_XBAR3 = 8'h3E;
  localparam logic [1:0] LINK_ONE = 2'h1;
  localparam logic [1:0] LINK_BOTH = 2'h3;

  // timing
  localparam int LMFC_PERIOD = 32;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } sls_regreq_s;

  typedef struct packed {
    logic valid;
    logic [LANES*LANE_W-1:0] data;
  } sls_lane_s;
endpackage : sls_pkg

/* File: tb/sls_sync_setup_bench.sv */
// Purpose: self-checking bench for the link sync and setup block
// Assumes: short LMFC period, inputs driven on the falling edge
// Notes: lane words are predicted from a crossbar and polarity model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module sls_sync_setup_bench;
  import sls_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  sls_regreq_s req = '0;
  logic [7:0] rdata;
  logic sysref;
  sls_lane_s lane_in;
  sls_lane_s lane_out;
  logic in_ready;
  logic out_ready = 1'b0;
  logic [1:0] link_en;
  logic locked;
  logic lmfc;
  int mismatches = 0;
  int samples_checked = 0;
  int mode = 0;
  int n;
  bit ok;
  bit dropped;
  logic [7:0] rv;
  logic [7:0] cfg[11];
  logic [7:0] xb[4];
  logic [7:0] pol;
  logic [7:0] s0;
  logic [7:0] s1;
  logic [63:0] w;
  logic [63:0] ev;
  logic [63:0] expq[$];
  always #12.5 mclk = ~mclk;
  sls_sync_setup #(.LMFC_LEN(8)) dut (.MCLK(mclk), .RST_N(rst_n), .REG_REQ(req),
    .REG_RDATA(rdata), .SYSREF(sysref), .LANE_IN(lane_in), .LANE_IN_READY(in_ready),
    .LANE_OUT(lane_out), .LANE_OUT_READY(out_ready), .LINK_EN(link_en),
    .SYNC_LOCKED(locked), .LMFC_PULSE(lmfc));
  sls_tx_model tx (.MCLK(mclk), .LANE_IN_READY(in_ready), .LANE_IN(lane_in), .SYSREF(sysref));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    req = '0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge mclk);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    req = '0;
    d = rdata;
  endtask : rd
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    rd(a, rv);
    `CHK(nm, e, rv)
  endtask : chk_rd
  task automatic wait_lock(output int c);
    c = 0;
    while (locked !== 1'b1 && c < 100) begin
      @(posedge mclk);
      c++;
    end
    if (c >= 100) begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_lock
  function automatic logic [63:0] lane_map(input logic [63:0] d);
    logic [2:0] p;
    lane_map = '0;
    for (int i = 0; i < LANES; i++) begin
      p = xb[i/2][(i%2)*3 +: 3];
      lane_map[8*i +: 8] = d[8*p +: 8] ^ {8{pol[i]}};
    end
  endfunction : lane_map
  // receiver: stalls held, random or off, by mode
  always @(negedge mclk) out_ready = (mode == 2) || (mode == 1 && $urandom_range(0, 2) != 0);
  always @(posedge mclk) begin
    if (rst_n && lane_out.valid === 1'b1 && out_ready) begin
      ev = (expq.size() > 0) ? expq.pop_front() : ~lane_out.data;
      `CHK("lane_out", ev, lane_out.data)
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    print_verdict();
  end
  initial begin
    rv = $urandom(43529);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    xb = '{RST_XBAR0, RST_XBAR1, RST_XBAR2, RST_XBAR3};
    for (int i = 0; i < 4; i++) chk_rd(ADDR_XBAR0 + 12'(i), xb[i], "xbar_reset");
    chk_rd(ADDR_SYNC_CTL, RST_BYTE, "sync_reset");
    chk_rd(12'h7FF, 8'h00, "unmapped");
    wr(ADDR_SYNC_STAT, 8'hFF);
    chk_rd(ADDR_SYNC_STAT, 8'h00, "status_ro");
    $display("test reset_values done");
    wr(ADDR_SYNC_CTL, 8'h01);
    wr(ADDR_SYNC_CTL, 8'h81);
    repeat (4) @(negedge mclk);
    `CHK("unarmed_lock", 1'b0, locked)
    wr(ADDR_SYNC_CTL, 8'hC1);
    wait_lock(n);
    `CHK("sc0_lock_time", 1'b1, n <= 3)
    wr(ADDR_SYNC_CTL, 8'h00);
    @(negedge mclk);
    `CHK("disable_lock", 1'b0, locked)
    $display("test subclass0 done");
    wr(ADDR_SUBCLASS, 8'h01);
    wr(ADDR_FC_DELAY_A, 8'h03);
    wr(ADDR_FC_VAR_A, 8'h02);
    wr(ADDR_SYNC_CTL, 8'h01);
    wr(ADDR_SYNC_CTL, 8'h81);
    wr(ADDR_SYNC_CTL, 8'hC1);
    repeat (12) @(negedge mclk);
    `CHK("no_edge_lock", 1'b0, locked)
    tx.sysref_edge();
    wait_lock(n);
    `CHK("sc1_lock_time", 1'b1, n >= 4 && n <= 10)
    rd(ADDR_SYNC_STAT, rv);
    `CHK("status_lock", 1'b1, rv[STAT_LOCK_BIT])
    chk_rd(ADDR_SYNC_CTL, 8'h81, "arm_cleared");
    dropped = 1'b0;
    n = 0;
    tx.sysref_edge();
    // frame clock runs free once locked: one pulse per period of 8
    repeat (16) begin
      @(negedge mclk);
      dropped |= (locked !== 1'b1);
      n += (lmfc === 1'b1);
    end
    `CHK("oneshot_hold", 1'b0, dropped)
    `CHK("lmfc_pulses", 2, n)
    $display("test subclass1 done");
    s0 = 8'h00;
    s1 = 8'h00;
    for (int i = 0; i < CFG_N; i++) begin
      cfg[i] = 8'($urandom);
      wr(ADDR_CFG0 + 12'(i), cfg[i]);
      s1 += cfg[i];
    end
    for (int i = CFG_L; i <= CFG_S; i++) if (i != 4) s0 += {3'h0, cfg[i][4:0]};
    s0 += cfg[CFG_L][SCR_BIT] + cfg[CFG_DENSITY][DENSITY_BIT] + cfg[CFG_NP][CFG_SUBCLASS_BIT];
    s0 += {5'h00, cfg[CFG_S][7:5]};
    wr(ADDR_LINK_CTL, 8'h00);
    chk_rd(ADDR_CHKSUM, s0, "csum_fields");
    wr(ADDR_LINK_CTL, 8'h40);
    chk_rd(ADDR_CHKSUM, s1, "csum_regs");
    $display("test checksum done");
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_LINK_CTL, 8'(v));
      // link enables are flops, one cycle behind the register
      @(negedge mclk);
      `CHK("link_en", {v == 3, v[0]}, link_en)
    end
    wr(ADDR_LINK_CTL, 8'h49);
    chk_rd(ADDR_LINK_CTL, 8'h49, "link_ctl");
    wr(ADDR_LINK_CTL, 8'h00);
    $display("test link_enable done");
    for (int i = 0; i < 4; i++) begin
      xb[i] = 8'($urandom) & 8'h3F;
      wr(ADDR_XBAR0 + 12'(i), xb[i]);
    end
    pol = 8'($urandom);
    wr(ADDR_POL_INV, pol);
    wr(ADDR_LINK_CTL, 8'h01);
    for (int k = 0; k < 22; k++) begin
      if (k == 2) begin
        tx.idle();
        @(negedge mclk);
        `CHK("buffer_full", 1'b0, in_ready)
        mode = 1;
      end
      w = {$urandom, $urandom};
      expq.push_back(lane_map(w));
      tx.send(w, ok);
      `CHK("lane_take", 1'b1, ok)
    end
    tx.idle();
    mode = 2;
    n = 0;
    while (expq.size() > 0 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    `CHK("drained", 0, expq.size())
    $display("test lane_path done");
    print_verdict();
  end
endmodule : sls_sync_setup_bench
`default_nettype wire

/* File: tb/sls_tx_model.sv */
// Purpose: transmitter side model: lane words with valid, and the reference pin
// Assumes: drives on the falling edge and holds a word until it is taken
// Notes: idle data is the inverse of the last word so a stale word never matches
`timescale 1ns/1ps
`default_nettype none
module sls_tx_model (
  input wire logic MCLK,
  input wire logic LANE_IN_READY,
  output sls_pkg::sls_lane_s LANE_IN,
  output logic SYSREF
);
  import sls_pkg::*;
  initial begin
    LANE_IN = '0;
    SYSREF = 1'b0;
  end
  // words are driven with valid and held until the receiver is seen ready
  task automatic send(input logic [63:0] w, output bit ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(negedge MCLK);
    LANE_IN = {1'b1, w};
    while (!ok && n < 50) begin
      @(posedge MCLK);
      ok = (LANE_IN_READY === 1'b1);
      n++;
    end
  endtask : send
  task automatic idle();
    @(negedge MCLK);
    LANE_IN = {1'b0, ~LANE_IN.data};
  endtask : idle
  // one rising edge after arming, held a few cycles for the synchronizer
  task automatic sysref_edge();
    @(negedge MCLK);
    SYSREF = 1'b1;
    repeat (3) @(negedge MCLK);
    SYSREF = 1'b0;
  endtask : sysref_edge
endmodule : sls_tx_model
`default_nettype wire

/* File: verilog/sls_buf.sv */
// Purpose: small valid/ready buffer in the lane data path
// Assumes: single clock, synchronous active-low reset
// Notes: ready and valid are flops so a receiver stall never drops a word
`timescale 1ns/1ps
`default_nettype none
module sls_buf #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign cnt_next = cnt_reg + CW'(push) - CW'(pop);
  assign out_data = mem_reg[rptr_reg];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : bump

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        mem_reg[wptr_reg] <= in_data;
        wptr_reg <= bump(wptr_reg);
      end
      if (pop) begin
        rptr_reg <= bump(rptr_reg);
      end
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next != FULL_CNT);
      out_valid <= (cnt_next != '0);
    end
  end

  chk_buf_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_reg == FULL_CNT |-> !in_ready)
    else $error("buffer full but still ready");
  cov_buf_full: cover property (@(posedge clk) disable iff (!rst_n)
    cnt_reg == FULL_CNT && !out_ready);
endmodule : sls_buf
`default_nettype wire

/* File: verilog/sls_sync_setup.sv */
// Purpose: receive data link layer setup: frame-clock alignment, lane map, polarity, links
// Assumes: register port and lane data on MCLK; SYSREF is an asynchronous pin
// Notes: alignment delay counts MCLK cycles; LMFC period is a module parameter
// Functional notes
// - sync control value 0x01 selects one-shot alignment, aligning once per arm.
// - value 0x81 enables the alignment machine, keeping the one-shot choice.
// - value 0xC1 arms the machine so it acts on the next SYSREF edge.
// - after SYSREF and completed alignment, status bit 3 of 0x03B reads 1.
// - polarity register bit x set inverts logical lane x data; clear leaves it.
// - four crossbar registers map physical input lanes onto logical lanes.
// - link enable field 1 enables link 0; 3 enables links 0 and 1.
// - link control also holds checksum mode in bit 6, dual link in bit 3.
// - SYSREF handled, delay and variance applied, then link established.
// - expected checksum: low byte of field sum, or of bytes 0x450-0x45A.
// - subclass 0 locks without needing any SYSREF input.
`timescale 1ns/1ps
`default_nettype none
module sls_sync_setup
  import sls_pkg::*;
#(
  parameter int LMFC_LEN = sls_pkg::LMFC_PERIOD
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire sls_pkg::sls_regreq_s REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic SYSREF,
  input wire sls_pkg::sls_lane_s LANE_IN,
  output logic LANE_IN_READY,
  output sls_pkg::sls_lane_s LANE_OUT,
  input wire logic LANE_OUT_READY,
  output logic [1:0] LINK_EN,
  output logic SYNC_LOCKED,
  output logic LMFC_PULSE
);
  import sls_pkg::*;

  typedef enum {ST_IDLE, ST_ARMED, ST_ALIGN, ST_LOCKED} sls_state_e;
  localparam int LMFC_W = $clog2(LMFC_LEN);

  sls_state_e state_reg, state_next;
  logic [7:0] sync_ctl_reg, link_ctl_reg, subclass_reg;
  logic [7:0] dly_a_reg, dly_b_reg, var_a_reg, var_b_reg, pol_reg;
  logic [7:0] xbar_reg [4];
  logic [7:0] cfg_reg [CFG_N];
  logic [DLY_W:0] dly_cnt_reg;
  logic [LMFC_W-1:0] lmfc_reg;
  logic sysref_m_reg, sysref_s_reg, sysref_d_reg;
  logic [7:0] rdata_next;

  // register decode
  wire wr = REG_REQ.wr;
  wire [11:0] addr = REG_REQ.addr;
  wire [7:0] wdata = REG_REQ.wdata;
  wire in_xbar = (addr >= ADDR_XBAR0) && (addr <= ADDR_XBAR3);
  wire in_cfg = (addr >= ADDR_CFG0) && (addr <= ADDR_CFG_LAST);
  wire [1:0] xbar_idx = addr[1:0];
  wire [3:0] cfg_idx = 4'(addr - ADDR_CFG0);
  wire sync_en = sync_ctl_reg[SYNC_EN_BIT];
  wire sync_arm = sync_ctl_reg[SYNC_ARM_BIT];
  wire oneshot = sync_ctl_reg[SYNC_ONESHOT_BIT];
  wire subclass1 = subclass_reg[SUBCLASS_BIT];
  wire sysref_edge = sysref_s_reg && !sysref_d_reg;
  wire align_done = (state_reg == ST_ALIGN) && (dly_cnt_reg == '0);
  wire [DLY_W:0] dly_load = {1'b0, dly_a_reg[DLY_W-1:0]} + {1'b0, var_a_reg[DLY_W-1:0]};
  wire link_run = LINK_EN[0] && (SYNC_LOCKED || !subclass1);

  // alignment machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sync_en && sync_arm) begin
          state_next = subclass1 ? ST_ARMED : ST_LOCKED;
        end
      end
      ST_ARMED: begin
        if (sysref_edge) begin
          state_next = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (align_done) begin
          state_next = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        // in subclass 1, continuous mode realigns on every edge; one-shot ignores further edges
        if (sysref_edge && subclass1 && !oneshot) begin
          state_next = ST_ALIGN;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (!sync_en) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
      dly_cnt_reg <= '0;
      lmfc_reg <= '0;
      sysref_m_reg <= 1'b0;
      sysref_s_reg <= 1'b0;
      sysref_d_reg <= 1'b0;
      SYNC_LOCKED <= 1'b0;
      LMFC_PULSE <= 1'b0;
      LINK_EN <= 2'h0;
    end else begin
      sysref_m_reg <= SYSREF;
      sysref_s_reg <= sysref_m_reg;
      sysref_d_reg <= sysref_s_reg;
      state_reg <= state_next;
      SYNC_LOCKED <= (state_next == ST_LOCKED);
      if (state_next == ST_ALIGN && state_reg != ST_ALIGN) begin
        dly_cnt_reg <= dly_load;
      end else if (dly_cnt_reg != '0) begin
        dly_cnt_reg <= dly_cnt_reg - (DLY_W+1)'(1);
      end
      // frame clock phase is restarted when the alignment delay count expires (align_done)
      if (align_done || lmfc_reg == LMFC_W'(LMFC_LEN - 1)) begin
        lmfc_reg <= '0;
      end else begin
        lmfc_reg <= lmfc_reg + LMFC_W'(1);
      end
      LMFC_PULSE <= align_done || (lmfc_reg == LMFC_W'(LMFC_LEN - 1));
      LINK_EN[0] <= link_ctl_reg[0];
      LINK_EN[1] <= (link_ctl_reg[1:0] == LINK_BOTH);
    end
  end

  // register file; a software write of the arm bit beats the hardware clear
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sync_ctl_reg <= RST_BYTE;
      link_ctl_reg <= RST_BYTE;
      subclass_reg <= RST_BYTE;
      dly_a_reg <= RST_BYTE;
      dly_b_reg <= RST_BYTE;
      var_a_reg <= RST_BYTE;
      var_b_reg <= RST_BYTE;
      pol_reg <= RST_BYTE;
      xbar_reg[0] <= RST_XBAR0;
      xbar_reg[1] <= RST_XBAR1;
      xbar_reg[2] <= RST_XBAR2;
      xbar_reg[3] <= RST_XBAR3;
      for (int i = 0; i < CFG_N; i++) begin
        cfg_reg[i] <= RST_BYTE;
      end
      REG_RDATA <= RST_BYTE;
    end else begin
      if (wr && addr == ADDR_SYNC_CTL) begin
        sync_ctl_reg <= wdata;
      end else if (align_done && oneshot) begin
        sync_ctl_reg[SYNC_ARM_BIT] <= 1'b0;
      end
      if (wr && addr == ADDR_LINK_CTL) link_ctl_reg <= wdata;
      if (wr && addr == ADDR_SUBCLASS) subclass_reg <= wdata;
      if (wr && addr == ADDR_FC_DELAY_A) dly_a_reg <= wdata;
      if (wr && addr == ADDR_FC_DELAY_B) dly_b_reg <= wdata;
      if (wr && addr == ADDR_FC_VAR_A) var_a_reg <= wdata;
      if (wr && addr == ADDR_FC_VAR_B) var_b_reg <= wdata;
      if (wr && addr == ADDR_POL_INV) pol_reg <= wdata;
      if (wr && in_xbar) xbar_reg[xbar_idx] <= wdata;
      if (wr && in_cfg) cfg_reg[cfg_idx] <= wdata;
      if (REG_REQ.rd) REG_RDATA <= rdata_next;
    end
  end

  // expected first-lane checksum, both methods
  logic [7:0] sum_fields, sum_bytes;
  always_comb begin
    sum_bytes = 8'h00;
    for (int i = 0; i < CFG_N; i++) begin
      sum_bytes = sum_bytes + cfg_reg[i];
    end
    sum_fields = 8'({3'h0, cfg_reg[CFG_L][4:0]} + {3'h0, cfg_reg[CFG_M][4:0]}
               + {3'h0, cfg_reg[CFG_K][4:0]} + {3'h0, cfg_reg[CFG_N1][4:0]}
               + {3'h0, cfg_reg[CFG_NP][4:0]} + {3'h0, cfg_reg[CFG_S][4:0]}
               + {7'h0, cfg_reg[CFG_L][SCR_BIT]} + {7'h0, cfg_reg[CFG_DENSITY][DENSITY_BIT]}
               + {7'h0, cfg_reg[CFG_NP][CFG_SUBCLASS_BIT]} + {5'h0, cfg_reg[CFG_S][7:5]});
  end
  wire csum_mode = link_ctl_reg[LINK_CSUM_BIT];
  wire [7:0] first_lane_config_sum = csum_mode ? sum_bytes : sum_fields;

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    if (in_xbar) rdata_next = xbar_reg[xbar_idx];
    else if (in_cfg) rdata_next = cfg_reg[cfg_idx];
    else begin
      case (addr)
        ADDR_SYNC_CTL: rdata_next = sync_ctl_reg;
        ADDR_SYNC_STAT: rdata_next = {4'h0, SYNC_LOCKED, 3'h0};
        ADDR_LINK_CTL: rdata_next = link_ctl_reg;
        ADDR_SUBCLASS: rdata_next = subclass_reg;
        ADDR_FC_DELAY_A: rdata_next = dly_a_reg;
        ADDR_FC_DELAY_B: rdata_next = dly_b_reg;
        ADDR_FC_VAR_A: rdata_next = var_a_reg;
        ADDR_FC_VAR_B: rdata_next = var_b_reg;
        ADDR_POL_INV: rdata_next = pol_reg;
        ADDR_CHKSUM: rdata_next = first_lane_config_sum;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // lane crossbar then polarity
  logic [LANES*LANE_W-1:0] mapped_data;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      wire [SEL_W-1:0] sel = xbar_reg[g/2][(g%2)*SEL_W +: SEL_W];
      wire [LANE_W-1:0] phys = LANE_IN.data[sel*LANE_W +: LANE_W];
      assign mapped_data[g*LANE_W +: LANE_W] = phys ^ {LANE_W{pol_reg[g]}};
    end
  endgenerate

  // words arriving while the link is down are accepted and dropped
  sls_buf #(.WIDTH(LANES*LANE_W), .DEPTH(2)) u_buf (
    .clk(MCLK),
    .rst_n(RST_N),
    .in_valid(LANE_IN.valid && link_run),
    .in_ready(LANE_IN_READY),
    .in_data(mapped_data),
    .out_valid(LANE_OUT.valid),
    .out_ready(LANE_OUT_READY),
    .out_data(LANE_OUT.data)
  );

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  chk_lock_status: assert property (SYNC_LOCKED == (state_reg == ST_LOCKED))
    else $error("lock flag disagrees with alignment state");
  chk_arm_edge: assert property (state_reg == ST_ARMED && sysref_edge && sync_en
    |=> state_reg == ST_ALIGN && dly_cnt_reg == $past(dly_load))
    else $error("armed machine missed sysref edge");
  chk_align_lock: assert property (align_done && sync_en |=> SYNC_LOCKED)
    else $error("alignment done without lock");
  chk_sc0_lock: assert property (state_reg == ST_IDLE && sync_en && sync_arm && !subclass1
    |=> SYNC_LOCKED)
    else $error("subclass 0 did not lock without sysref");
  chk_oneshot_hold: assert property (state_reg == ST_LOCKED && oneshot && sync_en
    |=> state_reg == ST_LOCKED)
    else $error("one-shot mode realigned");
  chk_disable_idle: assert property (!sync_en |=> state_reg == ST_IDLE && !SYNC_LOCKED)
    else $error("disabled machine not idle");
  chk_no_arm_idle: assert property (state_reg == ST_IDLE && !sync_arm |=> !SYNC_LOCKED)
    else $error("locked without arming");
  chk_link_pair: assert property (LINK_EN[1] |-> LINK_EN[0] && $past(link_ctl_reg[1:0]) == LINK_BOTH)
    else $error("link 1 on without link 0");
  chk_pol_lane0: assert property (pol_reg[0] |-> mapped_data[LANE_W-1:0] ==
    ~LANE_IN.data[g_lane[0].sel*LANE_W +: LANE_W])
    else $error("lane 0 polarity not inverted");
  chk_stat_read: assert property (REG_REQ.rd && addr == ADDR_SYNC_STAT
    |=> REG_RDATA[STAT_LOCK_BIT] == $past(SYNC_LOCKED))
    else $error("status read lost lock bit");

  cov_lock_sc1: cover property (state_reg == ST_ALIGN ##[1:40] SYNC_LOCKED);
  cov_realign: cover property (state_reg == ST_LOCKED && !oneshot ##1 state_reg == ST_ALIGN);
  cov_out_stall: cover property (LANE_OUT.valid && !LANE_OUT_READY ##1 !LANE_IN_READY);
endmodule : sls_sync_setup
`default_nettype wire
